// ### cms_defines.svh
// register offsets, encodings and fixed settings of the mode select block
`ifndef CMS_DEFINES_SVH
`define CMS_DEFINES_SVH
`define CMS_NREGS 16
`define CMS_RESET_VAL 8'h00
`define CMS_SW_REG 4'h0
`define CMS_LB_REG 4'h1
`define CMS_RX_REG0 4'h2
`define CMS_TX_REG0 4'h5
`define CMS_MISC_REG 4'h8
`define CMS_MODE_REG 4'hF
`define CMS_MODE_PIN 2'b00
`define CMS_MODE_MIXED 2'b10
`define CMS_MODE_SERIAL 2'b11
`define CMS_ADDR_PREFIX 4'hA
`define CMS_BYTE_BITS 4'h8
`define CMS_EQ_PIN_HI 4'h5
`define CMS_PE_PIN_HI 3'h4
`define CMS_AMP_400 2'h0
`define CMS_LB_LSB 4
`define CMS_LOS_LSB 4
`define CMS_AMP_LSB 4
`endif

// ### cms_pkg.sv
// types shared by the mode select block
package cms_pkg;
    typedef logic [2:0] cms_port3_t;
    typedef enum logic [5:0] {
        CMS_IDLE = 6'b000001,
        CMS_DEV = 6'b000010,
        CMS_ACK = 6'b000100,
        CMS_RX = 6'b001000,
        CMS_TX = 6'b010000,
        CMS_RACK = 6'b100000
    } cms_state_t;
endpackage : cms_pkg

// ### cms_mode_select.sv
// control source selection with its two-wire slave register bank
`timescale 1ns/1ps
`include "cms_defines.svh"

module cms_mode_select #(
    parameter int EQ_W = 4,
    parameter int PE_W = 3
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire cms_pkg::cms_port3_t addr_strap_i,
    input wire logic [1:0] sel_pins_i,
    input wire logic bicast_pin_i,
    input wire cms_pkg::cms_port3_t port_loopback_pins_i,
    input wire cms_pkg::cms_port3_t rx_boost_pins_i,
    input wire cms_pkg::cms_port3_t tx_boost_pins_i,
    output logic [1:0] control_mode_o,
    output logic [1:0] sel_o,
    output logic bicast_o,
    output cms_pkg::cms_port3_t port_loopback_controls_o,
    output wire logic [3*EQ_W-1:0] rx_boost_level_o,
    output wire logic [3*PE_W-1:0] tx_boost_level_o,
    output wire logic [5:0] out_amplitude_o,
    output cms_pkg::cms_port3_t pn_swap_o,
    output cms_pkg::cms_port3_t signal_loss_detect_o
);
    import cms_pkg::*;

    // ************************************************************
    // bus sampling and framing
    // ************************************************************
    logic scl_q, sda_q;
    logic [2:0] strap_q;
    cms_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] shreg_q;
    logic [7:0] ptr_q;
    logic ptr_seen_q, rw_q, sda_oe_q;
    logic [7:0] regs_q [`CMS_NREGS];
    logic scl_rise, scl_fall, start_c, stop_c, byte_done, rx_done;
    logic [7:0] rd_byte;

    // pointer beyond the bank reads zero and ignores writes
    function automatic logic is_mapped(input logic [7:0] p);
        return p[7:4] == 4'h0;
    endfunction : is_mapped
    function automatic logic addr_match(input logic [6:0] a,
                                        input logic [2:0] s);
        return a == {`CMS_ADDR_PREFIX, s};
    endfunction : addr_match
    // previous bus levels for edge and start/stop detection
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end
    // strap follows the pins on every clock, in reset or not; not a reset-time capture
    always_ff @(posedge ref_clk_i) begin
        strap_q <= addr_strap_i;
    end
    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_c = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
    assign byte_done = scl_fall & (cnt_q == `CMS_BYTE_BITS);
    assign rx_done = byte_done & (state_q == CMS_RX);
    assign rd_byte = is_mapped(ptr_q) ? regs_q[ptr_q[3:0]] : 8'h00;

    // ************************************************************
    // slave state machine; sda only ever pulled low, never a master
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= CMS_IDLE;
            cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            rw_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_c) begin
            state_q <= CMS_DEV;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (stop_c) begin
            state_q <= CMS_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                CMS_DEV, CMS_RX: begin
                    if (scl_rise && cnt_q != `CMS_BYTE_BITS) begin
                        shreg_q <= {shreg_q[6:0], sda_i};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        cnt_q <= 4'h0;
                        if (state_q == CMS_RX) begin
                            state_q <= CMS_ACK;
                            sda_oe_q <= 1'b1;
                        end else if (addr_match(shreg_q[7:1], strap_q)) begin
                            state_q <= CMS_ACK;
                            sda_oe_q <= 1'b1;
                            rw_q <= shreg_q[0];
                        end else begin
                            state_q <= CMS_IDLE;
                        end
                    end
                end
                CMS_ACK: begin
                    if (scl_fall && rw_q) begin
                        state_q <= CMS_TX;
                        sda_oe_q <= ~rd_byte[7];
                        shreg_q <= {rd_byte[6:0], 1'b0};
                        cnt_q <= 4'h1;
                    end else if (scl_fall) begin
                        state_q <= CMS_RX;
                        sda_oe_q <= 1'b0;
                    end
                end
                CMS_TX: begin
                    if (byte_done) begin
                        state_q <= CMS_RACK;
                        sda_oe_q <= 1'b0;
                        cnt_q <= 4'h0;
                    end else if (scl_fall) begin
                        sda_oe_q <= ~shreg_q[7];
                        shreg_q <= {shreg_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                CMS_RACK: begin
                    // a nack at the rising edge ends the read burst
                    if (scl_rise && sda_i) begin
                        state_q <= CMS_IDLE;
                    end else if (scl_fall) begin
                        state_q <= CMS_TX;
                        sda_oe_q <= ~rd_byte[7];
                        shreg_q <= {rd_byte[6:0], 1'b0};
                        cnt_q <= 4'h1;
                    end
                end
                default: begin
                    state_q <= CMS_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // open drain: the data level is constant low, only the enable moves
    always_ff @(posedge ref_clk_i) begin
        sda_o <= 1'b0;
    end
    assign sda_oe_o = sda_oe_q;

    // first written byte is the pointer; it advances per data byte
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || start_c) begin
            ptr_seen_q <= 1'b0;
            ptr_q <= rst_i ? 8'h00 : ptr_q;
        end else if (rx_done && !ptr_seen_q) begin
            ptr_q <= shreg_q;
            ptr_seen_q <= 1'b1;
        end else if (rx_done || (byte_done && state_q == CMS_TX)) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // ************************************************************
    // register bank
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `CMS_NREGS; i++) begin
                regs_q[i] <= `CMS_RESET_VAL;
            end
        end else if (rx_done && ptr_seen_q && is_mapped(ptr_q)) begin
            // reserved mode bits are not stored and read back as zero
            if (ptr_q[3:0] == `CMS_MODE_REG) begin
                regs_q[ptr_q[3:0]] <= {6'h00, shreg_q[1:0]};
            end else begin
                regs_q[ptr_q[3:0]] <= shreg_q;
            end
        end
    end

    // ************************************************************
    // control source selection
    // ************************************************************
    logic [1:0] mode;
    logic reg_ctl, serial;
    assign mode = regs_q[`CMS_MODE_REG][1:0];
    // undefined code 01 falls back to pin control
    assign reg_ctl = (mode == `CMS_MODE_MIXED) || (mode == `CMS_MODE_SERIAL);
    assign serial = mode == `CMS_MODE_SERIAL;

    // switch connectivity leaves the pins only in serial mode
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            control_mode_o <= `CMS_MODE_PIN;
            sel_o <= 2'b00;
            bicast_o <= 1'b0;
            port_loopback_controls_o <= 3'b000;
        end else begin
            control_mode_o <= mode;
            sel_o <= serial ? regs_q[`CMS_SW_REG][2:1] : sel_pins_i;
            bicast_o <= serial ? regs_q[`CMS_SW_REG][0] : bicast_pin_i;
            port_loopback_controls_o <= serial ?
                regs_q[`CMS_LB_REG][`CMS_LB_LSB +: 3] : port_loopback_pins_i;
        end
    end

    // per-port lane settings; pins give only two levels each
    for (genvar p = 0; p < 3; p++) begin : g_port
        localparam logic [3:0] RXA = `CMS_RX_REG0 + 4'(p);
        localparam logic [3:0] TXA = `CMS_TX_REG0 + 4'(p);
        logic [EQ_W-1:0] rx_q;
        logic [PE_W-1:0] tx_q;
        logic [1:0] amp_q;
        always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
                rx_q <= '0;
                tx_q <= '0;
                amp_q <= `CMS_AMP_400;
                pn_swap_o[p] <= 1'b0;
                signal_loss_detect_o[p] <= 1'b1;
            end else if (reg_ctl) begin
                rx_q <= regs_q[RXA][EQ_W-1:0];
                tx_q <= regs_q[TXA][PE_W-1:0];
                amp_q <= regs_q[TXA][`CMS_AMP_LSB +: 2];
                pn_swap_o[p] <= regs_q[`CMS_MISC_REG][p];
                signal_loss_detect_o[p] <=
                    regs_q[`CMS_MISC_REG][`CMS_LOS_LSB + p];
            end else begin
                rx_q <= rx_boost_pins_i[p] ? EQ_W'(`CMS_EQ_PIN_HI) : '0;
                tx_q <= tx_boost_pins_i[p] ? PE_W'(`CMS_PE_PIN_HI) : '0;
                amp_q <= `CMS_AMP_400;
                pn_swap_o[p] <= 1'b0;
                signal_loss_detect_o[p] <= 1'b1;
            end
        end
        assign rx_boost_level_o[p*EQ_W +: EQ_W] = rx_q;
        assign tx_boost_level_o[p*PE_W +: PE_W] = tx_q;
        assign out_amplitude_o[p*2 +: 2] = amp_q;
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_reset_pin;
        @(posedge ref_clk_i) rst_i |=> mode == `CMS_MODE_PIN &&
            regs_q[`CMS_LB_REG] == `CMS_RESET_VAL;
    endproperty
    a_reset_pin: assert property (p_reset_pin)
        else $error("registers not at default after reset");
    // port a tx boost is checked as a whole field: the high level is not 1
    property p_pin_switch;
        @(posedge ref_clk_i) disable iff (rst_i)
        !reg_ctl |=> sel_o == $past(sel_pins_i) &&
            tx_boost_level_o[PE_W-1:0] == ($past(tx_boost_pins_i[0]) ?
            PE_W'(`CMS_PE_PIN_HI) : '0);
    endproperty
    a_pin_switch: assert property (p_pin_switch)
        else $error("pin mode not following pins");
    property p_mixed_switch;
        @(posedge ref_clk_i) disable iff (rst_i)
        mode == `CMS_MODE_MIXED |=>
            port_loopback_controls_o == $past(port_loopback_pins_i);
    endproperty
    a_mixed_switch: assert property (p_mixed_switch)
        else $error("mixed mode loopback not from pins");
    property p_mixed_boost;
        @(posedge ref_clk_i) disable iff (rst_i)
        mode == `CMS_MODE_MIXED |=>
            rx_boost_level_o[EQ_W-1:0] ==
            $past(regs_q[`CMS_RX_REG0][EQ_W-1:0]);
    endproperty
    a_mixed_boost: assert property (p_mixed_boost)
        else $error("mixed mode boost not from register");
    property p_serial_regs;
        @(posedge ref_clk_i) disable iff (rst_i)
        mode == `CMS_MODE_SERIAL |=> bicast_o ==
            $past(regs_q[`CMS_SW_REG][0]) && port_loopback_controls_o ==
            $past(regs_q[`CMS_LB_REG][`CMS_LB_LSB +: 3]);
    endproperty
    a_serial_regs: assert property (p_serial_regs)
        else $error("serial mode output not from register");
    property p_addr_ack;
        @(posedge ref_clk_i) disable iff (rst_i || start_c || stop_c)
        state_q == CMS_DEV && byte_done |=>
            sda_oe_q == (shreg_q[7:4] == `CMS_ADDR_PREFIX &&
                         $past(shreg_q[3:1]) == $past(strap_q));
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledge wrong");
    property p_slave_only;
        @(posedge ref_clk_i) disable iff (rst_i)
        sda_oe_q |-> state_q == CMS_ACK || state_q == CMS_TX;
    endproperty
    a_slave_only: assert property (p_slave_only)
        else $error("data line driven outside slave slots");
    property p_amp_fixed;
        @(posedge ref_clk_i) disable iff (rst_i)
        !reg_ctl ##1 !reg_ctl |-> out_amplitude_o == {3{`CMS_AMP_400}};
    endproperty
    a_amp_fixed: assert property (p_amp_fixed)
        else $error("amplitude not fixed under pin control");
    property p_pin_subset;
        @(posedge ref_clk_i) disable iff (rst_i)
        !reg_ctl |=> pn_swap_o == 3'b000 &&
            (rx_boost_level_o[EQ_W-1:0] == '0 ||
             rx_boost_level_o[EQ_W-1:0] == EQ_W'(`CMS_EQ_PIN_HI));
    endproperty
    a_pin_subset: assert property (p_pin_subset)
        else $error("pin mode exposes register only feature");
endmodule : cms_mode_select

// ### cms_i2c_host.sv
// two-wire bus host model that reaches the mode select registers
`timescale 1ns/1ps
module cms_i2c_host (
    input wire logic ref_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // ****************************************
    // bus primitives
    // ****************************************
    // bus idles released; the shared data line has a pull-up outside
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // every change lands just after an edge, so scl stays >= 2 clocks level
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick
    // one bit: drive b (1 = release), sample the line while scl is high
    task automatic bit_x(input logic b, output logic r);
        sda_oe_o = ~b;
        tick(3);
        scl_o = 1'b1;
        tick(2);
        r = sda_i;
        tick(2);
        scl_o = 1'b0;
        tick(1);
    endtask : bit_x
    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_oe_o = 1'b0;
        tick(2);
        scl_o = 1'b1;
        tick(3);
        sda_oe_o = 1'b1;
        tick(3);
        scl_o = 1'b0;
        tick(1);
    endtask : start
    task automatic stop();
        sda_oe_o = 1'b1;
        tick(2);
        scl_o = 1'b1;
        tick(3);
        sda_oe_o = 1'b0;
        tick(4);
    endtask : stop
    // msb first, then a ninth bit left released for the acknowledge
    task automatic byte_x(input logic [7:0] b, output logic [7:0] r,
                          output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], r[i]);
        end
        bit_x(1'b1, nak);
    endtask : byte_x
    // ****************************************
    // register transfers
    // ****************************************
    // pointer byte first, then one data byte
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                      input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic n0, n1, n2;
        start();
        byte_x({dev, 1'b0}, r, n0);
        byte_x(ptr, r, n1);
        byte_x(d, r, n2);
        stop();
        ok = ~(n0 | n1 | n2);
    endtask : wr
    // pointer write, repeated start, one byte read and closed by a nack
    task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                      output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic n0, n1, n2, n3;
        start();
        byte_x({dev, 1'b0}, r, n0);
        byte_x(ptr, r, n1);
        start();
        byte_x({dev, 1'b1}, r, n2);
        byte_x(8'hFF, d, n3);
        stop();
        ok = ~(n0 | n1 | n2);
    endtask : rd
endmodule : cms_i2c_host

// ### testbench.sv
// self-checking bench for the mode select block
`timescale 1ns/1ps
`include "cms_defines.svh"
module testbench;
    import cms_pkg::*;
    logic ref_clk_i, rst_i, scl, host_oe, sda_oe, sda_o, bicast_pin;
    logic bicast, ok;
    logic [7:0] d;
    wire logic sda_line;
    cms_port3_t strap, lb_pins, rx_pins, tx_pins, lb, pn, signal_loss_detect;
    logic [1:0] sel_pins, mode, sel;
    wire logic [11:0] rx_lvl;
    wire logic [8:0] tx_lvl;
    wire logic [5:0] amp;
    int errors, num_checks;
    localparam logic [6:0] DEV = {`CMS_ADDR_PREFIX, 3'b101};
    // open-drain data line with a pull-up: low if any party pulls it
    assign sda_line = ~(host_oe | (sda_oe & ~sda_o));
    cms_mode_select dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .addr_strap_i(strap), .sel_pins_i(sel_pins),
        .bicast_pin_i(bicast_pin), .port_loopback_pins_i(lb_pins),
        .rx_boost_pins_i(rx_pins), .tx_boost_pins_i(tx_pins),
        .control_mode_o(mode), .sel_o(sel), .bicast_o(bicast),
        .port_loopback_controls_o(lb), .rx_boost_level_o(rx_lvl),
        .tx_boost_level_o(tx_lvl), .out_amplitude_o(amp), .pn_swap_o(pn),
        .signal_loss_detect_o(signal_loss_detect));
    cms_i2c_host host (.ref_clk_i(ref_clk_i), .sda_i(sda_line),
        .scl_o(scl), .sda_oe_o(host_oe));
    // ****************************************
    // helpers
    // ****************************************
    // 40 ns clock
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    // outputs are registered, so give pin changes a few clocks to land
    task automatic set_pins(input logic [1:0] s, input logic b,
                            input cms_port3_t l, r, t);
        sel_pins = s;
        bicast_pin = b;
        lb_pins = l;
        rx_pins = r;
        tx_pins = t;
        tick(3);
    endtask : set_pins
    // pin mode: two boost levels per port, 400 mV, no swap, loss detect on
    task automatic check_pin(input logic [1:0] s, input logic b,
                             input cms_port3_t l, r, t);
        logic [11:0] er;
        logic [8:0] et;
        er = '0;
        et = '0;
        for (int i = 0; i < 3; i++) begin
            if (r[i]) er[4*i +: 4] = `CMS_EQ_PIN_HI;
            if (t[i]) et[3*i +: 3] = `CMS_PE_PIN_HI;
        end
        set_pins(s, b, l, r, t);
        check("mode", mode, `CMS_MODE_PIN);
        check("sel", sel, s);
        check("bicast", bicast, b);
        check("loopback", lb, l);
        check("rx boost", rx_lvl, er);
        check("tx boost", tx_lvl, et);
        check("amplitude", amp, {3{`CMS_AMP_400}});
        check("pn swap", pn, 3'h0);
        check("loss detect", signal_loss_detect, 3'h7);
    endtask : check_pin
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        check_pin(2'b10, 1'b1, 3'b011, 3'b101, 3'b010);
        host.rd(DEV, 8'h0F, d, ok);
        check("read ack", ok, 1'b1);
        check("mode reg", d, 8'h00);
    endtask : t_reset
    // wrong prefix or strap is ignored; a moved strap moves the address
    task automatic t_addr();
        host.wr({4'h5, 3'b101}, 8'h01, 8'h70, ok);
        check("bad prefix ack", ok, 1'b0);
        host.wr({`CMS_ADDR_PREFIX, 3'b100}, 8'h01, 8'h70, ok);
        check("bad strap ack", ok, 1'b0);
        strap = 3'b010;
        tick(2);
        host.rd({`CMS_ADDR_PREFIX, 3'b010}, 8'h01, d, ok);
        check("moved strap ack", ok, 1'b1);
        check("loopback reg", d, 8'h00);
        strap = 3'b101;
        tick(2);
    endtask : t_addr
    // mixed: switch from pins, lane settings from registers
    task automatic t_mixed();
        host.wr(DEV, 8'h00, 8'h07, ok);
        host.wr(DEV, 8'h02, 8'h09, ok);
        host.wr(DEV, 8'h06, 8'h32, ok);
        host.wr(DEV, 8'h0F, 8'h02, ok);
        set_pins(2'b01, 1'b0, 3'b100, 3'b111, 3'b111);
        check("mode", mode, `CMS_MODE_MIXED);
        check("sel", sel, 2'b01);
        check("bicast", bicast, 1'b0);
        check("loopback", lb, 3'b100);
        check("rx boost", rx_lvl, 12'h009);
        check("tx boost", tx_lvl, {3'h0, 3'h2, 3'h0});
        check("amplitude", amp, 6'h0C);
        host.rd(DEV, 8'h02, d, ok);
        check("rx reg", d, 8'h09);
    endtask : t_mixed
    // serial: pins ignored, loopback from register bits 6 to 4
    task automatic t_serial();
        host.wr(DEV, 8'h01, 8'h50, ok);
        host.wr(DEV, 8'h08, 8'h26, ok);
        host.wr(DEV, 8'h0F, 8'h03, ok);
        set_pins(2'b00, 1'b0, 3'b010, 3'b000, 3'b000);
        check("mode", mode, `CMS_MODE_SERIAL);
        check("sel", sel, 2'b11);
        check("bicast", bicast, 1'b1);
        check("loopback", lb, 3'b101);
        check("rx boost", rx_lvl, 12'h009);
        check("pn swap", pn, 3'b110);
        check("loss detect", signal_loss_detect, 3'b010);
    endtask : t_serial
    // a second reset in mid-run drops back to pin control and defaults
    task automatic t_rerst();
        rst_i = 1'b1;
        tick(2);
        rst_i = 1'b0;
        tick(1);
        check_pin(2'b11, 1'b0, 3'b001, 3'b010, 3'b101);
        host.rd(DEV, 8'h01, d, ok);
        check("loopback reg", d, 8'h00);
        // a pointer past the bank must not alias onto the mode register
        host.wr(DEV, 8'h1F, 8'h03, ok);
        check("unmapped write ack", ok, 1'b1);
        check("mode after unmapped", mode, `CMS_MODE_PIN);
        host.rd(DEV, 8'h1F, d, ok);
        check("unmapped read", d, 8'h00);
        host.rd(DEV, 8'h08, d, ok);
        check("lane reg", d, 8'h00);
    endtask : t_rerst
    // main sequence: reset held four clocks, then every scenario in turn
    initial begin
        errors = 0;
        num_checks = 0;
        rst_i = 1'b1;
        strap = 3'b101;
        sel_pins = 2'b00;
        bicast_pin = 1'b0;
        lb_pins = 3'h0;
        rx_pins = 3'h0;
        tx_pins = 3'h0;
        tick(4);
        rst_i = 1'b0;
        tick(2);
        t_reset();
        t_addr();
        t_mixed();
        t_serial();
        t_rerst();
        test_done();
    end
    // watchdog: the whole run needs well under ten thousand clocks
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        test_done();
    end
endmodule : testbench
